// ===== src/ppc_phy_end.sv
// Operation
// - Fixed 125 MHz clock supplied by surroundings.
// - Request in P1 with idle starts detect.
// - Controller drops request after done strobe in P1.
// - Request in P0 without idle enters loopback.
// - Disparity force makes encoder use negative.
// - Polarity invert flips all decoder input bits.
// - Power state codes P0, P0s, P1, P2.
// - Data valid only with valid data.
// - Done strobe lasts exactly one cycle.
// - Inferred idle drives idle output high.
// - Without inference idle is inverted signal detect.
// - Status codes 000 to 011 as documented.
// - Status codes 100 to 111 as documented.
// - Inference select chooses idle inference method; code only tells zero (none) from nonzero (run of invalid cycles).
// - Signal detect high above threshold.
// PHY end of the control/status port.
// Assumes far-present, level and force-idle indications arrive asynchronously and are resynchronised here; codes, code valid and events are not.
`timescale 1ns/100ps
`default_nettype none
module ppc_phy_end (
  ppc_if.phy bus,
  input wire logic force_idle,
  input wire logic [9:0] rx_code,
  input wire logic rx_code_valid,
  input wire logic rx_level_above,
  input wire logic rx_far_present,
  input wire logic [5:0] rx_events,
  output logic [9:0] dec_in,
  output logic enc_force_neg,
  output logic signal_detect,
  output logic loopback_en,
  output logic detect_busy
);

  typedef enum {
    PPC_IDLE,
    PPC_DETECT,
    PPC_PWR
  } ppc_state_t;

  ppc_state_t state;
  logic [2:0] lvl_s1, lvl_s2, lvl_s3;
  logic lvl_sig, lvl_far, lvl_idle;
  logic req_q;
  logic [ppc_pkg::PPC_CNT_W-1:0] cnt;
  logic [ppc_pkg::PPC_CNT_W-1:0] idle_cnt;
  logic [1:0] pwr_q;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  // Only stage two reads stage one, so no logic ever sees a metastable value.
  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      lvl_s1 <= 3'h0;
      lvl_s2 <= 3'h0;
      lvl_s3 <= 3'h0;
    end else begin
      lvl_s1 <= {rx_far_present, rx_level_above, force_idle};
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
    end
  end

  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      lvl_sig <= 1'b0;
      lvl_far <= 1'b0;
      lvl_idle <= 1'b0;
    end else begin
      if (lvl_s2[1] == lvl_s3[1]) begin
        lvl_sig <= lvl_s3[1];
      end
      if (lvl_s2[2] == lvl_s3[2]) begin
        lvl_far <= lvl_s3[2];
      end
      if (lvl_s2[0] == lvl_s3[0]) begin
        lvl_idle <= lvl_s3[0];
      end
    end
  end

  assign signal_detect = lvl_sig;

  // Polarity inversion sits directly ahead of the decoder.
  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      dec_in <= 10'h000;
      enc_force_neg <= 1'b0;
    end else begin
      dec_in <= bus.decoder_polarity_invert ? ~rx_code : rx_code;
      enc_force_neg <= bus.force_neg_disparity;
    end
  end

  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= bus.detect_loop_req;
    end
  end

  // The request edge picks the operation, so later state changes do not retarget it.
  // pwr_q resets to the controller's reset state, so leaving reset reports no change.
  // A power change made while a detect or power change is busy is not seen.
  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      state <= PPC_IDLE;
      cnt <= '0;
      loopback_en <= 1'b0;
      pwr_q <= ppc_pkg::PPC_P1;
      bus.phy_done <= 1'b0;
    end else begin
      bus.phy_done <= 1'b0;
      pwr_q <= bus.power_state;
      if (!bus.detect_loop_req) begin
        loopback_en <= 1'b0;
      end
      case (state)
        PPC_IDLE: begin
          if (bus.detect_loop_req && !req_q) begin
            if (bus.power_state == ppc_pkg::PPC_P1 && lvl_idle) begin
              state <= PPC_DETECT;
              cnt <= '0;
            end else if (bus.power_state == ppc_pkg::PPC_P0 && !lvl_idle) begin
              loopback_en <= 1'b1;
            end
          end else if (bus.power_state != ppc_pwr_prev(pwr_q)) begin
            state <= PPC_PWR;
            cnt <= '0;
          end
        end
        PPC_DETECT: begin
          cnt <= cnt + 1'b1;
          if (cnt == ppc_pkg::PPC_CNT_W'(ppc_pkg::PPC_DETECT_CYC - 1)) begin
            bus.phy_done <= 1'b1;
            state <= PPC_IDLE;
          end
        end
        PPC_PWR: begin
          cnt <= cnt + 1'b1;
          if (cnt == ppc_pkg::PPC_CNT_W'(ppc_pkg::PPC_PWR_CYC - 1)) begin
            bus.phy_done <= 1'b1;
            state <= PPC_IDLE;
          end
        end
        default: begin
          state <= PPC_IDLE;
        end
      endcase
    end
  end

  function automatic ppc_pkg::ppc_pwr_t ppc_pwr_prev(input logic [1:0] p);
    ppc_pwr_prev = ppc_pkg::ppc_pwr_t'(p);
  endfunction

  assign detect_busy = (state == PPC_DETECT);

  // Inferred idle: no valid code for a run of cycles.
  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      idle_cnt <= '0;
    end else if (rx_code_valid) begin
      idle_cnt <= '0;
    end else if (idle_cnt != ppc_pkg::PPC_CNT_W'(ppc_pkg::PPC_IDLE_CYC)) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // A detection result outranks receive events; events colliding with it are lost.
  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      bus.elec_idle <= 1'b1;
      bus.data_valid <= 1'b0;
      bus.rx_status <= ppc_pkg::PPC_ST_OK;
    end else begin
      if (bus.idle_infer_sel == ppc_pkg::PPC_SEL_NONE) begin
        bus.elec_idle <= ~lvl_sig;
      end else begin
        bus.elec_idle <= (idle_cnt == ppc_pkg::PPC_CNT_W'(ppc_pkg::PPC_IDLE_CYC));
      end
      bus.data_valid <= rx_code_valid;
      if (state == PPC_DETECT && lvl_far &&
          cnt == ppc_pkg::PPC_CNT_W'(ppc_pkg::PPC_DETECT_CYC - 1)) begin
        bus.rx_status <= ppc_pkg::PPC_ST_RX_DET;
      end else if (rx_events[5]) begin
        bus.rx_status <= ppc_pkg::PPC_ST_DISP_ERR;
      end else if (rx_events[4]) begin
        bus.rx_status <= ppc_pkg::PPC_ST_DEC_ERR;
      end else if (rx_events[3]) begin
        bus.rx_status <= ppc_pkg::PPC_ST_EB_OVF;
      end else if (rx_events[2]) begin
        bus.rx_status <= ppc_pkg::PPC_ST_EB_UNF;
      end else if (rx_events[1]) begin
        bus.rx_status <= ppc_pkg::PPC_ST_SKP_DEL;
      end else if (rx_events[0]) begin
        bus.rx_status <= ppc_pkg::PPC_ST_SKP_ADD;
      end else begin
        bus.rx_status <= ppc_pkg::PPC_ST_OK;
      end
    end
  end

endmodule // ppc_phy_end
`default_nettype wire

// ===== src/ppc_pkg.sv
// Package for the PHY-interface control and status block.
// Assumes both ends run on one 125 MHz clock, clk_sys.
package ppc_pkg;

  typedef enum logic [1:0] {
    PPC_P0  = 2'b00,
    PPC_P0S = 2'b01,
    PPC_P1  = 2'b10,
    PPC_P2  = 2'b11
  } ppc_pwr_t;

  localparam logic [2:0] PPC_ST_OK = 3'h0;
  localparam logic [2:0] PPC_ST_SKP_ADD = 3'h1;
  localparam logic [2:0] PPC_ST_SKP_DEL = 3'h2;
  localparam logic [2:0] PPC_ST_RX_DET = 3'h3;
  localparam logic [2:0] PPC_ST_DEC_ERR = 3'h4;
  localparam logic [2:0] PPC_ST_EB_OVF = 3'h5;
  localparam logic [2:0] PPC_ST_EB_UNF = 3'h6;
  localparam logic [2:0] PPC_ST_DISP_ERR = 3'h7;

  localparam int PPC_CLK_MHZ = 125;
  localparam int PPC_DETECT_NS = 1000;
  localparam int PPC_DETECT_CYC = (PPC_DETECT_NS * PPC_CLK_MHZ) / 1000;
  localparam int PPC_PWR_NS = 64;
  localparam int PPC_PWR_CYC = (PPC_PWR_NS * PPC_CLK_MHZ) / 1000;
  localparam int PPC_CNT_W = 8;
  localparam int PPC_SEL_W = 3;
  localparam logic [PPC_SEL_W-1:0] PPC_SEL_NONE = 3'h0;
  localparam int PPC_IDLE_CYC = 16;

endpackage

// ===== src/ppc_if.sv
// Interface joining the link controller and the PHY control/status port.
// Assumes both ends share clk_sys and rstn.
`timescale 1ns/100ps
`default_nettype none
interface ppc_if (
  input wire logic clk_sys,
  input wire logic rstn
);
  ppc_pkg::ppc_pwr_t power_state;
  logic detect_loop_req;
  logic force_neg_disparity;
  logic decoder_polarity_invert;
  logic [ppc_pkg::PPC_SEL_W-1:0] idle_infer_sel;
  logic data_valid;
  logic phy_done;
  logic elec_idle;
  logic [2:0] rx_status;

  modport ctrl (
    input clk_sys, rstn, data_valid, phy_done, elec_idle, rx_status,
    output power_state, detect_loop_req, force_neg_disparity,
    decoder_polarity_invert, idle_infer_sel
  );
  modport phy (
    input clk_sys, rstn, power_state, detect_loop_req, force_neg_disparity,
    decoder_polarity_invert, idle_infer_sel,
    output data_valid, phy_done, elec_idle, rx_status
  );
endinterface
`default_nettype wire

// ===== src/ppc_phy.sv
// Holds no logic: the PHY end of the port is module ppc_phy_end.
// Assumes nothing of its surroundings.

// ===== src/ppc_ctrl_end.sv
// Link-controller end of the control/status port.
// Assumes the user logic pulses detect_start for one cycle and holds the other commands as levels on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ppc_ctrl_end (
  ppc_if.ctrl bus,
  input wire logic [1:0] pwr_cmd,
  input wire logic detect_start,
  input wire logic loop_on,
  input wire logic compliance_first,
  input wire logic invert_cmd,
  input wire logic [2:0] infer_cmd,
  output logic detect_done,
  output logic far_present,
  output logic [2:0] last_status,
  output logic idle_seen
);

  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      bus.power_state <= ppc_pkg::PPC_P1;
      bus.force_neg_disparity <= 1'b0;
      bus.decoder_polarity_invert <= 1'b0;
      bus.idle_infer_sel <= ppc_pkg::PPC_SEL_NONE;
    end else begin
      bus.power_state <= ppc_pkg::ppc_pwr_t'(pwr_cmd);
      bus.force_neg_disparity <= compliance_first;
      bus.decoder_polarity_invert <= invert_cmd;
      bus.idle_infer_sel <= infer_cmd;
    end
  end

  // Request held until a done strobe in P1, or while loopback is wanted in P0.
  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      bus.detect_loop_req <= 1'b0;
    end else if (detect_start) begin
      bus.detect_loop_req <= 1'b1;
    end else if (bus.phy_done && bus.power_state == ppc_pkg::PPC_P1) begin
      bus.detect_loop_req <= 1'b0;
    end else if (bus.power_state == ppc_pkg::PPC_P0) begin
      bus.detect_loop_req <= loop_on;
    end
  end

  always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
    if (!bus.rstn) begin
      detect_done <= 1'b0;
      far_present <= 1'b0;
      last_status <= ppc_pkg::PPC_ST_OK;
      idle_seen <= 1'b1;
    end else begin
      detect_done <= bus.phy_done;
      if (bus.rx_status == ppc_pkg::PPC_ST_RX_DET) begin
        far_present <= 1'b1;
      end else if (detect_start) begin
        far_present <= 1'b0;
      end
      if (bus.data_valid) begin
        last_status <= bus.rx_status;
      end
      idle_seen <= bus.elec_idle;
    end
  end

endmodule // ppc_ctrl_end
`default_nettype wire

// ===== dv/ppc_chk.sv
// Checker for the control/status interface between the two ends.
// Assumes one clk_sys domain and the asynchronous active-low rstn.
`timescale 1ns/100ps
`default_nettype none
module ppc_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] power_state,
  input wire logic detect_loop_req,
  input wire logic phy_done,
  input wire logic elec_idle,
  input wire logic [2:0] rx_status
);
  localparam int DET_MIN = 124;
  localparam int DET_MAX = 127;
  localparam int PWR_MAX = 10;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Skips the first edge of reset, before the asynchronous reset has taken hold.
  logic rst_seen = 1'b0;
  always @(posedge clk_sys) begin
    rst_seen <= !rstn;
  end
  done_pulse_a: assert property (phy_done |=> !phy_done)
    else $error("done strobe longer than one cycle");
  det_bound_a: assert property (
    $rose(detect_loop_req) && power_state == ppc_pkg::PPC_P1 |-> ##[DET_MIN:DET_MAX] phy_done)
    else $error("detect did not complete in time");
  no_early_a: assert property (
    $rose(detect_loop_req) && power_state == ppc_pkg::PPC_P1 |=> !phy_done [*8])
    else $error("detect completed too early");
  det_status_a: assert property (rx_status == ppc_pkg::PPC_ST_RX_DET |-> phy_done)
    else $error("receiver detected shown outside done");
  det_cause_a: assert property (
    rx_status == ppc_pkg::PPC_ST_RX_DET |-> detect_loop_req && power_state == ppc_pkg::PPC_P1)
    else $error("receiver detected without request in P1");
  pwr_done_a: assert property ($changed(power_state) |-> ##[1:PWR_MAX] phy_done)
    else $error("power change not completed");
  req_drop_a: assert property (
    phy_done && detect_loop_req && power_state == ppc_pkg::PPC_P1 |-> ##[1:2] !detect_loop_req)
    else $error("request held after done");
  rst_idle_a: assert property (disable iff (1'b0) !rstn && rst_seen |-> elec_idle && !phy_done)
    else $error("wrong idle or done during reset");
  cover property (rx_status == ppc_pkg::PPC_ST_RX_DET);
  cover property (phy_done && !detect_loop_req);
  cover property (detect_loop_req && power_state == ppc_pkg::PPC_P0);
endmodule // ppc_chk
`default_nettype wire

// ===== dv/pipe_phy_control_status_tb.sv
// Testbench joining the controller end and the PHY end through the interface.
// Assumes the design files under src/ are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pipe_phy_control_status_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] pwr_cmd = 2'h2;
  logic detect_start = 1'b0, loop_on = 1'b0, compliance_first = 1'b0, invert_cmd = 1'b0;
  logic [2:0] infer_cmd = 3'h0;
  logic force_idle = 1'b1, rx_code_valid = 1'b1, rx_level_above = 1'b1, rx_far_present = 1'b1;
  logic [9:0] rx_code = 10'h000;
  logic [5:0] rx_events = 6'h00;
  logic [9:0] dec_in;
  logic enc_force_neg, signal_detect, loopback_en, detect_done, far_present, idle_seen, detect_busy;
  logic [2:0] last_status;
  logic [4:0] notes[$];
  logic [4:0] note;
  logic [1:0] pw[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [2:0] ev[6] = '{3'h1, 3'h2, 3'h6, 3'h5, 3'h4, 3'h7};
  int errors = 0;
  int n_checks = 0;
  ppc_if i_ppc_if (.clk_sys(clk_sys), .rstn(rstn));
  ppc_ctrl_end i_ppc_ctrl_end (.bus(i_ppc_if), .pwr_cmd(pwr_cmd), .detect_start(detect_start),
    .loop_on(loop_on), .compliance_first(compliance_first), .invert_cmd(invert_cmd),
    .infer_cmd(infer_cmd), .detect_done(detect_done), .far_present(far_present),
    .last_status(last_status), .idle_seen(idle_seen));
  ppc_phy_end i_ppc_phy_end (.bus(i_ppc_if), .force_idle(force_idle), .rx_code(rx_code),
    .rx_code_valid(rx_code_valid), .rx_level_above(rx_level_above),
    .rx_far_present(rx_far_present), .rx_events(rx_events), .dec_in(dec_in),
    .enc_force_neg(enc_force_neg), .signal_detect(signal_detect), .loopback_en(loopback_en),
    .detect_busy(detect_busy));
  ppc_chk i_ppc_chk (.clk_sys(clk_sys), .rstn(rstn), .power_state(i_ppc_if.power_state),
    .detect_loop_req(i_ppc_if.detect_loop_req), .phy_done(i_ppc_if.phy_done),
    .elec_idle(i_ppc_if.elec_idle), .rx_status(i_ppc_if.rx_status));

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Each power change ends in one done strobe with a clean status.
  task automatic set_pwr(input logic [1:0] p);
    notes.push_back({p, 3'h0});
    pwr_cmd = p;
    cyc(12);
  endtask

  task automatic detect(input logic far, input logic [2:0] st);
    int k;
    rx_far_present = far;
    cyc(4);
    notes.push_back({2'h2, st});
    detect_start = 1'b1;
    cyc(1);
    detect_start = 1'b0;
    cyc(1);
    check("detect_busy", {9'h0, detect_busy}, 10'h001);
    for (k = 0; k < 200 && detect_done !== 1'b1; k++) cyc(1);
    check("detect_done", {9'h0, detect_done}, 10'h001);
    cyc(1);
    check("far_present", {9'h0, far_present}, {9'h0, far});
    check("detect_idle", {9'h0, detect_busy}, 10'h000);
    cyc(4);
  endtask

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Every done strobe must match the oldest note left by the driver.
  always @(posedge clk_sys) begin
    if (rstn && i_ppc_if.phy_done === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected_done", 10'h001, 10'h000);
      end else begin
        note = notes.pop_front();
        check("done_state", {5'h0, i_ppc_if.power_state, i_ppc_if.rx_status}, {5'h0, note});
      end
    end
  end

  initial begin
    #200us;
    errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    void'($urandom(59));
    cyc(12);
    rstn = 1'b1;
    cyc(4);
    foreach (pw[i]) set_pwr(pw[i]);
    detect(1'b1, ppc_pkg::PPC_ST_RX_DET);
    detect(1'b0, ppc_pkg::PPC_ST_OK);
    set_pwr(2'h0);
    force_idle = 1'b0;
    cyc(4);
    loop_on = 1'b1;
    cyc(6);
    check("loopback_on", {9'h0, loopback_en}, 10'h001);
    loop_on = 1'b0;
    force_idle = 1'b1;
    cyc(6);
    loop_on = 1'b1;
    cyc(6);
    check("loopback_refused", {9'h0, loopback_en}, 10'h000);
    loop_on = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rx_code = 10'($urandom);
      invert_cmd = 1'($urandom);
      compliance_first = 1'($urandom);
      cyc(5);
      check("dec_in", dec_in, invert_cmd ? ~rx_code : rx_code);
      check("enc_force_neg", {9'h0, enc_force_neg}, {9'h0, compliance_first});
      rx_level_above = 1'($urandom);
      cyc(6);
      check("idle_seen", {9'h0, idle_seen}, {9'h0, ~rx_level_above});
      check("signal_detect", {9'h0, signal_detect}, {9'h0, rx_level_above});
      check("elec_idle", {9'h0, i_ppc_if.elec_idle}, {9'h0, ~rx_level_above});
    end
    infer_cmd = 3'h1;
    rx_code_valid = 1'b0;
    cyc(24);
    check("inferred_idle", {9'h0, i_ppc_if.elec_idle}, 10'h001);
    check("valid_low", {9'h0, i_ppc_if.data_valid}, 10'h000);
    rx_code_valid = 1'b1;
    cyc(5);
    check("valid_high", {9'h0, i_ppc_if.data_valid}, 10'h001);
    foreach (ev[i]) begin
      rx_events = 6'h01 << i;
      cyc(1);
      rx_events = 6'h00;
      cyc(1);
      check("last_status", {7'h0, last_status}, {7'h0, ev[i]});
      cyc(5);
    end
    cyc(10);
    check("notes_left", 10'(notes.size()), 10'h000);
    stop_test();
  end
endmodule // pipe_phy_control_status_tb
`default_nettype wire
